/* logic/erc_rx_counters.sv */
/*
  E1 receive performance counters and spare/Sa bit capture with a
  classic Wishbone slave. Assumes framer strobes are one-cycle pulses
  on mclk, already in this clock domain.
*/
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module erc_rx_counters #(
  parameter int unsigned SIM_FE_CYC = erc_pkg::SIM_FE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_bit_stb,
  input  wire logic        fas_stb,
  input  wire logic        fas_ok,
  input  wire logic        fas_first_bit,
  input  wire logic        nfas_stb,
  input  wire logic [3:0]  nfas_frame,
  input  wire logic [7:0]  nfas_word,
  input  wire logic        smf_stb,
  input  wire logic        smf_crc_err,
  input  wire logic        hdb3_viol,
  input  wire logic        hdb3_ext_viol,
  input  wire logic        bipolar_viol,
  input  wire logic        prbs_bit_err,
  input  wire logic        prbs_sync_status,
  input  wire logic        one_second_event,
  input  wire logic        multiframe_begin_event
);
  import erc_pkg::*;

  typedef struct packed {
    logic [NCNT-1:0][15:0] cnt;
    logic [NCNT-1:0][15:0] hold;
    logic [NCNT-1:0]       frz;
    logic [NCNT-1:0]       frz_prev;
    logic [7:0]            cfg;
    logic [4:0][7:0]       sa;
    logic [4:0][7:0]       sa_acc;
    logic [7:0]            si_acc;
    logic                  intl;
    logic                  s13;
    logic                  s15;
    logic [2:0]            sa6_nib;
    logic                  bsync;
    logic [1:0]            bad_run;
    logic [1:0]            good_run;
    logic                  mf_lost;
    logic [1:0]            mf_good;
    logic                  mf_fe_seen;
    logic [15:0]           sim_tmr;
    logic [1:0]            bit_div;
    logic                  ack;
    logic [7:0]            dat;
  } erc_state_s;

  erc_state_s      q;
  erc_state_s      d;
  logic [NCNT-1:0] inc;
  logic [NCNT-1:0] rise;
  logic            crc_mode;
  logic            sim;
  logic            sa_valid;
  logic            req;
  logic            take;
  logic            sim_tick;
  logic            smf_end;
  logic [3:0]      nib;
  logic [1:0]      lc;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    d        = q;
    crc_mode = q.cfg[CFG_RFS+1];
    sim      = q.cfg[CFG_SIM];
    lc       = q.cfg[CFG_LC +: 2];
    sa_valid = crc_mode || (q.cfg[CFG_RFS +: 2] == RFS_DBL);
    req      = wb_cyc_i && wb_stb_i && !q.ack;
    take     = wb_cyc_i && wb_stb_i && q.ack;
    sim_tick = sim && (q.sim_tmr == 16'(SIM_FE_CYC - 1));
    smf_end  = nfas_stb && (nfas_frame == FRM_SMF_A || nfas_frame == FRM_SMF_B);
    nib      = {q.sa6_nib, nfas_word[2]};
    inc      = '0;

    // Basic frame sync: lose on a run of bad FAS, regain on good ones
    if (fas_stb) begin
      if (!fas_ok) begin
        d.good_run = 2'h0;
        if (q.bad_run != FAS_LOSS) d.bad_run = q.bad_run + 2'h1;
        if (q.bad_run == FAS_LOSS - 2'h1) d.bsync = 1'b0;
      end else begin
        d.bad_run = 2'h0;
        if (q.good_run != FAS_GAIN) d.good_run = q.good_run + 2'h1;
        if (q.good_run == FAS_GAIN - 2'h1) d.bsync = 1'b1;
      end
    end

    // Multiframe sync follows basic sync, needs clean multiframes
    if (fas_stb && !fas_ok) d.mf_fe_seen = 1'b1;
    if (!crc_mode || !q.bsync) begin
      d.mf_lost = 1'b1;
      d.mf_good = 2'h0;
    end else if (multiframe_begin_event) begin
      d.mf_fe_seen = fas_stb && !fas_ok;
      if (q.mf_lost) begin
        d.mf_good = q.mf_fe_seen ? 2'h0 : q.mf_good + 2'h1;
        if (!q.mf_fe_seen && q.mf_good == MF_GAIN - 2'h1) d.mf_lost = 1'b0;
      end
    end

    // Simulation pacing: 250 us timer and received bit divider
    d.sim_tmr = (!sim || sim_tick) ? 16'h0000 : q.sim_tmr + 16'h0001;
    if (!sim) d.bit_div = 2'h0;
    else if (rx_bit_stb) d.bit_div = q.bit_div + 2'h1;

    // Increment sources per counter
    inc[CNT_FE] = sim ? sim_tick : (fas_stb && !fas_ok && q.bsync);
    if (sim) inc[CNT_CV] = rx_bit_stb && (q.bit_div == 2'h3);
    else if (lc == LC_AMI) inc[CNT_CV] = bipolar_viol;
    else if (lc != LC_NRZ)
      inc[CNT_CV] = q.cfg[CFG_EXTD] ? hdb3_ext_viol : hdb3_viol;
    inc[CNT_CR] = crc_mode && (sim ? smf_stb : smf_stb && smf_crc_err && !q.mf_lost);
    inc[CNT_EB] = crc_mode && (sim ? smf_stb : nfas_stb && !nfas_word[7]
                  && (nfas_frame == FRM_13 || nfas_frame == FRM_15));
    if (q.cfg[CFG_PRBS])
      inc[CNT_CC] = sim ? (rx_bit_stb && q.bit_div[0])
                        : (prbs_bit_err && prbs_sync_status);
    else
      inc[CNT_CC] = crc_mode && (sim ? smf_stb : smf_end && !q.mf_lost
                    && (nib == SA6_PAT_A || nib == SA6_PAT_B));

    // Counters and their read buffers
    for (int k = 0; k < NCNT; k++) begin
      rise[k]       = q.frz[k] && !q.frz_prev[k];
      d.frz_prev[k] = q.frz[k];
      if (q.cfg[CFG_ECM]) begin
        if (one_second_event) begin
          d.hold[k] = q.cnt[k];
          d.cnt[k]  = inc[k] ? 16'h0001 : 16'h0000;  // Keeps the event of this cycle
        end else if (inc[k] && q.cnt[k] != CNT_MAX) begin
          d.cnt[k] = q.cnt[k] + 16'h0001;
        end
      end else if (rise[k]) begin
        d.cnt[k] = 16'h0000;
      end else begin
        if (inc[k] && q.cnt[k] != CNT_MAX) d.cnt[k] = q.cnt[k] + 16'h0001;
        if (!q.frz[k]) d.hold[k] = q.cnt[k];
      end
    end

    // Sa and spare bit gathering over the multiframe
    if (nfas_stb) begin
      for (int j = 0; j < 5; j++) begin
        d.sa_acc[j][nfas_frame[3:1]] = nfas_word[4-j];
      end
      d.si_acc[nfas_frame[3:1]] = nfas_word[7];
      d.sa6_nib = nib[2:0];
    end
    if (multiframe_begin_event) begin
      d.sa  = sa_valid ? q.sa_acc : '0;
      d.s13 = crc_mode && q.si_acc[6];
      d.s15 = crc_mode && q.si_acc[7];
    end
    if (!crc_mode) begin
      d.s13 = 1'b0;
      d.s15 = 1'b0;
    end
    if (crc_mode) d.intl = 1'b1;
    else if (fas_stb) d.intl = fas_first_bit;

    // Wishbone: answer one cycle after the strobe, act at the ack edge
    d.ack = req;
    if (req) begin
      d.dat = 8'h00;
      for (int k = 0; k < NCNT; k++) begin
        if (wb_adr_i == 8'(OFS_CNT_BASE + OFS_CNT_STEP * k)) d.dat = q.hold[k][7:0];
        if (wb_adr_i == 8'(OFS_CNT_BASE + OFS_CNT_STEP * k + OFS_CNT_HI))
          d.dat = q.hold[k][15:8];
      end
      for (int j = 0; j < 5; j++) begin
        if (wb_adr_i == 8'(OFS_SA_BASE + OFS_SA_STEP * j)) d.dat = q.sa[j];
      end
      if (wb_adr_i == OFS_SPARE) d.dat = {5'h00, q.s15, q.s13, q.intl};
      if (wb_adr_i == OFS_CFG) d.dat = q.cfg;
      if (wb_adr_i == OFS_FREEZE) d.dat = {3'h0, q.frz};
    end
    if (take && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == OFS_CFG) d.cfg = wb_dat_i[7:0];
      if (wb_adr_i == OFS_FREEZE) d.frz = wb_dat_i[NCNT-1:0];
    end
    if (take && !wb_we_i) begin
      for (int k = 0; k < NCNT; k++) begin
        if (wb_adr_i == 8'(OFS_CNT_BASE + OFS_CNT_STEP * k + OFS_CNT_HI))
          d.frz[k] = 1'b0;
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Frozen by ce so the whole block pauses cleanly
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.cfg      <= CFG_RESET;
      q.frz      <= FREEZE_RESET;
      q.frz_prev <= FREEZE_RESET;
      q.intl     <= 1'b1;
      q.mf_lost  <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = {24'h000000, q.dat};

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sat_hold_a: assert property (ce && q.cnt[CNT_FE] == CNT_MAX && !one_second_event
    && !rise[CNT_FE] |=> q.cnt[CNT_FE] == CNT_MAX) else $error("counter wrapped");
  frz_clear_a: assert property (ce && take && !wb_we_i
    && wb_adr_i == 8'(OFS_CNT_BASE + OFS_CNT_HI) |=> !q.frz[CNT_FE])
    else $error("freeze bit not cleared by high byte read");
  frz_rise_a: assert property (ce && rise[CNT_CV] && !q.cfg[CFG_ECM]
    |=> q.cnt[CNT_CV] == 16'h0000 && $stable(q.hold[CNT_CV]))
    else $error("freeze edge did not clear counter");
  sec_latch_a: assert property (ce && q.cfg[CFG_ECM] && one_second_event
    |=> q.hold[CNT_CR] == $past(q.cnt[CNT_CR])) else $error("second latch wrong");
  fe_gate_a: assert property (ce && !q.bsync && !sim && !q.cfg[CFG_ECM]
    && !rise[CNT_FE] |=> $stable(q.cnt[CNT_FE])) else $error("framing counted unsynced");
  cv_nrz_a: assert property (ce && lc == LC_NRZ && !sim && !q.cfg[CFG_ECM]
    && !rise[CNT_CV] |=> $stable(q.cnt[CNT_CV])) else $error("NRZ counted violation");
  intl_one_a: assert property (ce && crc_mode |=> q.intl)
    else $error("international spare not one");
  spare_zero_a: assert property (ce && !crc_mode ##1 ce |-> !q.s13 && !q.s15)
    else $error("spare bits not zero");
  sa_update_a: assert property (ce && multiframe_begin_event && sa_valid
    |=> q.sa == $past(q.sa_acc)) else $error("Sa registers not refreshed");
  sync_loss_a: assert property (ce && fas_stb && !fas_ok
    && q.bad_run == FAS_LOSS - 2'h1 |=> !q.bsync) else $error("sync not lost");

  freeze_read_c: cover property (rise[CNT_FE] ##[1:40] take && !wb_we_i && !q.frz[CNT_FE]);
  second_latch_c: cover property (q.cfg[CFG_ECM] && one_second_event && q.cnt[CNT_CR] != 0);
  sa6_count_c: cover property (inc[CNT_CC] && !sim && !q.cfg[CFG_PRBS]);
endmodule : erc_rx_counters
`default_nettype wire

/* logic/erc_pkg.sv */
/*
  Constants for the E1 receive error counter and spare bit block:
  register map, field positions, reset values, line codes, timing.
  Assumes a 200 MHz mclk and a byte-wide register set on Wishbone.
*/
package erc_pkg;
  // ************************************************************
  // Counter indices
  // ************************************************************
  localparam int NCNT   = 5;
  localparam int CNT_FE = 0;
  localparam int CNT_CV = 1;
  localparam int CNT_CR = 2;
  localparam int CNT_EB = 3;
  localparam int CNT_CC = 4;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [7:0] OFS_CNT_BASE = 8'h00;  // Counter k low at base + step*k
  localparam logic [7:0] OFS_CNT_STEP = 8'h08;
  localparam logic [7:0] OFS_CNT_HI   = 8'h04;  // High byte beside the low byte
  localparam logic [7:0] OFS_SA_BASE  = 8'h28;  // Sa4..Sa8 one word apart
  localparam logic [7:0] OFS_SA_STEP  = 8'h04;
  localparam logic [7:0] OFS_SPARE    = 8'h3c;
  localparam logic [7:0] OFS_CFG      = 8'h40;
  localparam logic [7:0] OFS_FREEZE   = 8'h44;

  // ************************************************************
  // Configuration fields and reset values
  // ************************************************************
  localparam int CFG_ECM  = 0;  // one_second_latch_mode
  localparam int CFG_EXTD = 1;  // extended_violation_detect
  localparam int CFG_LC   = 2;  // line_code_select, two bits
  localparam int CFG_PRBS = 4;  // prbs_monitor_select
  localparam int CFG_RFS  = 5;  // receive_format_select, two bits
  localparam int CFG_SIM  = 7;  // alarm simulation
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [4:0] FREEZE_RESET = 5'h00;
  localparam int SPR_INTL = 0;
  localparam int SPR_S13  = 1;
  localparam int SPR_S15  = 2;

  localparam logic [1:0] LC_NRZ  = 2'b00;
  localparam logic [1:0] LC_AMI  = 2'b10;
  localparam logic [1:0] RFS_DBL = 2'b01;

  // ************************************************************
  // Frame numbers, patterns and timing
  // ************************************************************
  localparam logic [3:0] FRM_13    = 4'hd;
  localparam logic [3:0] FRM_15    = 4'hf;
  localparam logic [3:0] FRM_SMF_A = 4'h7;
  localparam logic [3:0] FRM_SMF_B = 4'hf;
  localparam logic [3:0] SA6_PAT_A = 4'h1;
  localparam logic [3:0] SA6_PAT_B = 4'h3;
  localparam logic [1:0] FAS_LOSS  = 2'h3;
  localparam logic [1:0] FAS_GAIN  = 2'h2;
  localparam logic [1:0] MF_GAIN   = 2'h2;
  localparam int MCLK_PERIOD_NS = 5;
  localparam int SIM_FE_TIME_NS = 250000;
  localparam int SIM_FE_CYCLES  = (SIM_FE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
endpackage : erc_pkg

/* verif/erc_framer_model.sv */
/*
  Stand-in for the E1 receive framer and line decoder: one-cycle strobes,
  each followed by an idle edge so that no call ever redrives a strobe.
  Assumes its tasks are called just after a rising mclk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module erc_framer_model (
  input  wire logic       mclk,
  output logic            fas_stb,
  output logic            fas_ok,
  output logic            fas_first_bit,
  output logic            nfas_stb,
  output logic      [3:0] nfas_frame,
  output logic      [7:0] nfas_word,
  output logic      [2:0] viol,
  output logic            sec,
  output logic            mfb,
  output logic            bit_stb,
  output logic            smf_stb,
  output logic            smf_err,
  output logic            prbs_err,
  output logic            prbs_sync
);
  // ************************************************************
  // Strobe tasks
  // ************************************************************
  // Quiet at time zero
  initial begin
    {fas_stb, fas_ok, fas_first_bit, nfas_stb, sec, mfb} = 6'h00;
    nfas_frame = 4'h0;
    nfas_word = 8'h00;
    viol = 3'h0;
    {bit_stb, smf_stb, smf_err, prbs_err, prbs_sync} = 5'h00;
  end
  // First bit is the inverse of ok so doubleframe readback differs from one
  task automatic fas(input logic ok);
    fas_ok <= ok;
    fas_first_bit <= ~ok;
    fas_stb <= 1'b1;
    @(posedge mclk);
    fas_stb <= 1'b0;
    fas_ok <= ~ok;  // Stale qualifier must not be trusted
    @(posedge mclk);
  endtask : fas
  // Service word of an odd frame
  task automatic nfas(input logic [3:0] f, input logic [7:0] w);
    nfas_frame <= f;
    nfas_word <= w;
    nfas_stb <= 1'b1;
    @(posedge mclk);
    nfas_stb <= 1'b0;
    nfas_word <= ~w;
    @(posedge mclk);
  endtask : nfas
  // Violations, one-second tick and multiframe begin as single pulses
  task automatic pulse(input logic [2:0] v, input logic s, input logic m);
    viol <= v;
    sec <= s;
    mfb <= m;
    @(posedge mclk);
    viol <= 3'h0;
    sec <= 1'b0;
    mfb <= 1'b0;
    @(posedge mclk);
  endtask : pulse
  // Bit, submultiframe, CRC error and PRBS error pulses; PRBS lock is a level
  task automatic aux(input logic [3:0] p, input logic sync);
    {bit_stb, smf_stb, smf_err, prbs_err} <= p;
    prbs_sync <= sync;
    @(posedge mclk);
    {bit_stb, smf_stb, smf_err, prbs_err} <= 4'h0;
    @(posedge mclk);
  endtask : aux
endmodule : erc_framer_model
`default_nettype wire

/* verif/testbench.sv */
/*
  Self-checking bench for the receive error counters and Sa capture.
  Assumes the framer model beside it and a classic Wishbone master here.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import erc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        b_stb, s_stb, s_err, p_err, p_sync;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        f_stb, f_ok, f_fb, n_stb, sec, mfb;
  logic [3:0]  n_frm;
  logic [7:0]  n_wrd;
  logic [2:0]  viol;
  int          mismatches = 0;
  int          tests_run = 0;
  // ************************************************************
  // Clock, instances, watchdog
  // ************************************************************
  always #2.5 mclk = ~mclk;
  erc_framer_model u_frm (.mclk(mclk), .fas_stb(f_stb), .fas_ok(f_ok), .fas_first_bit(f_fb),
    .nfas_stb(n_stb), .nfas_frame(n_frm), .nfas_word(n_wrd), .viol(viol), .sec(sec), .mfb(mfb),
    .bit_stb(b_stb), .smf_stb(s_stb), .smf_err(s_err), .prbs_err(p_err), .prbs_sync(p_sync));
  erc_rx_counters #(.SIM_FE_CYC(20)) u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_bit_stb(b_stb), .fas_stb(f_stb),
    .fas_ok(f_ok), .fas_first_bit(f_fb), .nfas_stb(n_stb), .nfas_frame(n_frm),
    .nfas_word(n_wrd), .smf_stb(s_stb), .smf_crc_err(s_err), .hdb3_viol(viol[0]),
    .hdb3_ext_viol(viol[1]), .bipolar_viol(viol[2]), .prbs_bit_err(p_err),
    .prbs_sync_status(p_sync), .one_second_event(sec), .multiframe_begin_event(mfb));
  // Generous bound: the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    summarize();
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One classic cycle; waits for ack, takes data at that edge, then releases
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= {24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    check(q, {24'h0, e});
  endtask : rd_chk
  // Freeze, read low then high, freeze bit must have cleared itself
  task automatic cnt(input int k, input logic [15:0] e);
    logic [31:0] q;
    logic [7:0]  lo;
    lo = 8'(OFS_CNT_BASE + OFS_CNT_STEP * k);
    wb(1'b1, OFS_FREEZE, 8'(1 << k), q);
    rd_chk(lo, e[7:0]);
    rd_chk(lo + OFS_CNT_HI, e[15:8]);
    rd_chk(OFS_FREEZE, 8'h00);
  endtask : cnt
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] q;
    rd_chk(OFS_CFG, CFG_RESET);
    rd_chk(OFS_SPARE, 8'h01);
    wb(1'b1, 8'h48, 8'hff, q);
    rd_chk(8'h48, 8'h00);
  endtask : t_reset
  // Bad word before sync is ignored; two bad words while synced count
  task automatic t_fe();
    u_frm.fas(1'b0);
    u_frm.fas(1'b1);
    u_frm.fas(1'b1);
    u_frm.fas(1'b0);
    u_frm.fas(1'b0);
    cnt(CNT_FE, 16'h0002);
    u_frm.fas(1'b1);
  endtask : t_fe
  // Line code table: NRZ, AMI, HDB3, HDB3 extended; one source pulsed at a time
  task automatic t_cv();
    logic [31:0] q;
    logic [7:0]  cfg [4] = '{8'h00, 8'h08, 8'h04, 8'h06};
    cnt(CNT_CV, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, OFS_CFG, cfg[i], q);
      u_frm.pulse(3'b001, 1'b0, 1'b0);
      u_frm.pulse(3'b010, 1'b0, 1'b0);
      u_frm.pulse(3'b100, 1'b0, 1'b0);
      cnt(CNT_CV, (i == 0) ? 16'h0000 : 16'h0001);
    end
  endtask : t_cv
  // One-second mode latches then restarts the count
  task automatic t_sec();
    logic [31:0] q;
    wb(1'b1, OFS_CFG, 8'h09, q);
    u_frm.pulse(3'b100, 1'b0, 1'b0);
    u_frm.pulse(3'b100, 1'b0, 1'b0);
    u_frm.pulse(3'b000, 1'b1, 1'b0);
    u_frm.pulse(3'b100, 1'b0, 1'b0);
    rd_chk(OFS_CNT_STEP, 8'h02);
    u_frm.pulse(3'b000, 1'b1, 1'b0);
    rd_chk(OFS_CNT_STEP, 8'h01);
  endtask : t_sec
  // Sa bits by frame, spare bits, then doubleframe readback
  task automatic t_sa();
    logic [31:0] q;
    wb(1'b1, OFS_CFG, 8'h40, q);
    for (int f = 1; f < 16; f += 2) begin
      u_frm.nfas(4'(f), (f == 1) ? 8'h10 : (f == 15) ? 8'h81 : (f == 13) ? 8'h80 : 8'h00);
    end
    u_frm.pulse(3'b000, 1'b0, 1'b1);
    rd_chk(OFS_SA_BASE, 8'h01);
    rd_chk(OFS_SA_BASE + 8'h10, 8'h80);
    rd_chk(OFS_SPARE, 8'h07);
    wb(1'b1, OFS_CFG, 8'h20, q);
    u_frm.fas(1'b1);
    rd_chk(OFS_SPARE, 8'h00);
    u_frm.fas(1'b0);
    rd_chk(OFS_SPARE, 8'h01);
  endtask : t_sa
  // PRBS errors count only while locked; a pulse while ce is low is dropped
  task automatic t_prbs();
    logic [31:0] q;
    wb(1'b1, OFS_CFG, 8'h10, q);
    u_frm.aux(4'b0001, 1'b0);
    u_frm.aux(4'b0001, 1'b1);
    ce <= 1'b0;
    u_frm.aux(4'b0001, 1'b1);
    ce <= 1'b1;
    cnt(CNT_CC, 16'h0001);
  endtask : t_prbs
  // Alarm simulation: every fourth bit, and once per submultiframe
  task automatic t_sim();
    logic [31:0] q;
    wb(1'b1, OFS_CFG, 8'hc0, q);
    for (int i = 0; i < 8; i++) begin
      u_frm.aux(4'b1000, 1'b0);
    end
    u_frm.aux(4'b0100, 1'b0);
    u_frm.aux(4'b0110, 1'b0);
    cnt(CNT_CV, 16'h0002);
    cnt(CNT_CR, 16'h0002);
    cnt(CNT_EB, 16'h0002);
    cnt(CNT_CC, 16'h0002);
  endtask : t_sim
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_fe();
    t_cv();
    t_sec();
    t_sa();
    t_prbs();
    t_sim();
    summarize();
  end
endmodule : testbench
`default_nettype wire
